// [adc_fmt_pkg.sv]
// Shared constants and types for the converter output link and its receiver
package adc_fmt_pkg;
  localparam int SAMPLE_W = 12;
  localparam int PAIRS = 6;
  localparam int PCLK_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_DIV = LINK_PERIOD_NS / PCLK_NS;
  localparam int PHASE_STEPS = 8;
  // Device register byte offsets
  localparam logic [7:0] POWER_OFS = 8'h00;
  localparam logic [7:0] CLOCK_OFS = 8'h04;
  localparam logic [7:0] OUTCFG_OFS = 8'h08;
  localparam logic [7:0] FORMAT_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Receiver register byte offsets
  localparam logic [7:0] RX_CTRL_OFS = 8'h00;
  localparam logic [7:0] RX_WORD_OFS = 8'h04;
  localparam logic [7:0] RX_STATUS_OFS = 8'h08;
  // Power register fields
  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_NAP_BIT = 1;
  // Clock register fields
  localparam int CLK_STAB_BIT = 0;
  localparam int CLK_SHIFT_LSB = 1;
  localparam int CLK_INV_BIT = 3;
  // Output config fields
  localparam int OUT_CUR_LSB = 0;
  localparam int OUT_TERM_BIT = 3;
  localparam int OUT_DIS_BIT = 4;
  // Format register fields
  localparam int FMT_TWOS_BIT = 0;
  localparam int FMT_RAND_BIT = 1;
  localparam int FMT_ALT_BIT = 2;
  localparam int FMT_TEST_BIT = 3;
  localparam int FMT_PAT_LSB = 4;
  // Receiver control fields
  localparam int RX_RAND_BIT = 0;
  localparam int RX_ALT_BIT = 1;
  localparam int RX_INV_BIT = 2;
  localparam int RX_SHIFT_LSB = 3;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Sample range and code constants
  localparam logic signed [12:0] LEVEL_MAX = 13'sh07FF;
  localparam logic signed [12:0] LEVEL_MIN = -13'sh0800;
  localparam logic [11:0] MID_CODE = 12'h800;
  localparam logic [12:0] CHECKER_A = 13'h1555;
  localparam logic [12:0] CHECKER_B = 13'h0AAA;
  // Drive current codes, microamps
  localparam logic [13:0] CUR_3500 = 14'd3500;
  localparam logic [13:0] CUR_4000 = 14'd4000;
  localparam logic [13:0] CUR_4500 = 14'd4500;
  localparam logic [13:0] CUR_3000 = 14'd3000;
  localparam logic [13:0] CUR_2500 = 14'd2500;
  localparam logic [13:0] CUR_2100 = 14'd2100;
  localparam logic [13:0] CUR_1750 = 14'd1750;
  // Recovery times
  localparam int NAP_WAKE_SAMPLES = 100;
  localparam int SLEEP_FIXED_NS = 100000;
  localparam int SLEEP_SAMPLES = 2500;
  localparam int SLEEP_FIXED_CYC = (SLEEP_FIXED_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int SLEEP_WAIT_CYC = SLEEP_FIXED_CYC + SLEEP_SAMPLES * LINK_DIV;
  localparam int NAP_WAIT_CYC = NAP_WAKE_SAMPLES * LINK_DIV;
  typedef enum logic [1:0] {PAT_ONES, PAT_ZEROS, PAT_ALT, PAT_CHECKER} pattern_t;
endpackage

// [adc_link_if.sv]
// Link between the converter output end and the capturing receiver
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
  logic [adc_fmt_pkg::PAIRS-1:0] data_pair;
  logic over_range_flag;
  logic forwarded_clock;
  logic link_oe;
  modport device (
    output data_pair,
    output over_range_flag,
    output forwarded_clock,
    output link_oe
  );
  modport receiver (
    input data_pair,
    input over_range_flag,
    input forwarded_clock,
    input link_oe
  );
endinterface
`default_nettype wire

// [adc_output_formatter.sv]
// Converter output end: sample formatting, DDR link drive and config registers
//
// How it works
// (RULE1) Twelve bits on six DDR pairs, plus flag, clock
// (RULE2) Even bits while clock low, odd while high
// (RULE3) Drive current code selects seven levels, 3.5mA default
// (RULE4) Internal termination doubles driver current
// (RULE5) Over-range flag follows data through same pipeline
// (RULE6) Flag presented while clock low with invert off
// (RULE7) Flag driven zero in second half
// (RULE8) Clock delayed by 0, 45, 90, 135 degrees
// (RULE9) Phase shift only with duty stabilizer enabled
// (RULE10) Separate bit inverts forwarded clock polarity
// (RULE11) Offset binary default, two's complement flips MSB
// (RULE12) Out-of-range input saturates and sets flag
// (RULE13) Randomizer XORs upper bits with LSB
// (RULE14) Receiver XORs upper bits with LSB back
// (RULE15) Alternate polarity inverts odd data bits
// (RULE16) Randomizer and alternate polarity independent
// (RULE17) Test patterns force flag and data
// (RULE18) Test pattern overrides all other formatting
// (RULE19) Output disable releases all link outputs
// (RULE20) Sleep by register or parallel-mode pin
// (RULE21) Receiver discards data until sleep recovery wait ends
// (RULE22) Nap wake valid after 100 sample cycles
// (RULE23) Stopped clock in nap means sleep wait
// (RULE24) Order: code, randomize, invert, pattern, DDR mux
`timescale 1ns/100ps
`default_nettype none
module adc_output_formatter #(
  parameter int DIV = adc_fmt_pkg::LINK_DIV
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic signed [12:0] sample_level, // Converter level, signed
  input wire logic sample_valid, // New level this cycle
  input wire logic parallel_mode, // Strap: parallel programming mode
  input wire logic power_down_pin, // Sleep request in parallel mode
  output logic [13:0] drive_current_ua, // Effective driver current
  output logic termination_on, // Internal termination enabled
  output logic core_awake, // Converter core powered
  output logic data_settled, // Wake recovery finished
  adc_link_if.device link // Output link
);
  import adc_fmt_pkg::*;

  localparam int PW = $clog2(DIV);
  localparam int STEP = DIV / PHASE_STEPS;
  localparam int HALF = DIV / 2;

  initial begin
    if (DIV < PHASE_STEPS || DIV % PHASE_STEPS != 0)
      $error("DIV must be a positive multiple of eight");
  end

  logic [7:0] power_reg;
  logic [7:0] clock_reg;
  logic [7:0] outcfg_reg;
  logic [7:0] format_reg;
  logic [1:0] mode_sync1;
  logic [1:0] mode_sync2;
  logic sleeping;
  logic napping;
  logic signed [12:0] held_level;
  logic [PW-1:0] phase;
  logic [11:0] out_word;
  logic out_flag;
  logic alt_toggle;
  logic [6:0] wake_count;
  logic [11:0] next_word;
  logic next_flag;
  logic [PW-1:0] clk_phase;

  function automatic logic [13:0] current_ua(input logic [2:0] code);
    case (code)
      3'h1: current_ua = CUR_4000;
      3'h2: current_ua = CUR_4500;
      3'h4: current_ua = CUR_3000;
      3'h5: current_ua = CUR_2500;
      3'h6: current_ua = CUR_2100;
      3'h7: current_ua = CUR_1750;
      default: current_ua = CUR_3500;
    endcase
  endfunction

  // APB slave: one wait state, so writes land at the ready edge
  wire access = psel && penable;
  wire hit = (paddr == POWER_OFS) || (paddr == CLOCK_OFS) || (paddr == OUTCFG_OFS)
    || (paddr == FORMAT_OFS) || (paddr == STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !hit;
      if (access && !pready && !pwrite) begin
        case (paddr)
          POWER_OFS: prdata <= {24'h000000, power_reg};
          CLOCK_OFS: prdata <= {24'h000000, clock_reg};
          OUTCFG_OFS: prdata <= {24'h000000, outcfg_reg};
          FORMAT_OFS: prdata <= {24'h000000, format_reg};
          STATUS_OFS: prdata <= {29'h00000000, sleeping, core_awake, data_settled};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire wr = access && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_reg <= REG_RESET;
      clock_reg <= REG_RESET;
      outcfg_reg <= REG_RESET;
      format_reg <= REG_RESET;
    end else if (wr) begin
      if (paddr == POWER_OFS) power_reg <= pwdata[7:0];
      if (paddr == CLOCK_OFS) clock_reg <= pwdata[7:0];
      if (paddr == OUTCFG_OFS) outcfg_reg <= pwdata[7:0];
      if (paddr == FORMAT_OFS) format_reg <= pwdata[7:0];
    end
  end

  // Pins from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sync1 <= 2'b00;
      mode_sync2 <= 2'b00;
    end else begin
      mode_sync1 <= {parallel_mode, power_down_pin};
      mode_sync2 <= mode_sync1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
      napping <= 1'b0;
      core_awake <= 1'b0;
    end else begin
      sleeping <= mode_sync2[1] ? mode_sync2[0] : power_reg[PWR_SLEEP_BIT]; // RULE20
      napping <= !mode_sync2[1] && power_reg[PWR_NAP_BIT];
      core_awake <= !(sleeping || napping);
    end
  end

  // Count samples since the core woke; hold off the settled mark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_count <= 7'h00;
      data_settled <= 1'b0;
    end else if (!core_awake) begin
      wake_count <= 7'h00;
      data_settled <= 1'b0;
    end else if (phase == PW'(DIV - 1) && !data_settled) begin
      wake_count <= wake_count + 7'h01;
      data_settled <= (wake_count == 7'(NAP_WAKE_SAMPLES - 1)); // RULE22
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_level <= 13'sh0000;
    end else if (sample_valid) begin
      held_level <= sample_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_current_ua <= CUR_3500;
      termination_on <= 1'b0;
    end else begin
      termination_on <= outcfg_reg[OUT_TERM_BIT];
      drive_current_ua <= outcfg_reg[OUT_TERM_BIT] // RULE4
        ? (current_ua(outcfg_reg[OUT_CUR_LSB +: 3]) << 1)
        : current_ua(outcfg_reg[OUT_CUR_LSB +: 3]); // RULE3
    end
  end

  // Formatting chain, fixed order; pattern last so it sees none of the rest
  always_comb begin
    logic [12:0] pat;
    pat = 13'h0000;
    next_flag = (held_level > LEVEL_MAX) || (held_level < LEVEL_MIN); // RULE5
    if (held_level > LEVEL_MAX) next_word = 12'hFFF; // RULE12
    else if (held_level < LEVEL_MIN) next_word = 12'h000;
    else next_word = held_level[11:0] ^ MID_CODE; // RULE11
    if (format_reg[FMT_TWOS_BIT]) next_word[11] = !next_word[11];
    if (format_reg[FMT_RAND_BIT]) next_word[11:1] = next_word[11:1] ^ {11{next_word[0]}}; // RULE13
    if (format_reg[FMT_ALT_BIT]) next_word = next_word ^ 12'hAAA; // RULE15 RULE16
    case (pattern_t'(format_reg[FMT_PAT_LSB +: 2]))
      PAT_ONES: pat = 13'h1FFF;
      PAT_ZEROS: pat = 13'h0000;
      PAT_ALT: pat = alt_toggle ? 13'h0000 : 13'h1FFF;
      PAT_CHECKER: pat = alt_toggle ? CHECKER_B : CHECKER_A;
      default: pat = 13'h0000;
    endcase
    if (format_reg[FMT_TEST_BIT]) begin
      {next_flag, next_word} = pat; // RULE17 RULE18 RULE24
    end
  end

  // One link period per sample; clock stops while the core is down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
      out_word <= 12'h000;
      out_flag <= 1'b0;
      alt_toggle <= 1'b0;
    end else if (!core_awake) begin
      phase <= '0;
    end else begin
      phase <= (phase == PW'(DIV - 1)) ? '0 : phase + PW'(1);
      if (phase == PW'(DIV - 1)) begin
        out_word <= next_word; // RULE5
        out_flag <= next_flag;
        alt_toggle <= !alt_toggle;
      end
    end
  end

  // Shift is ignored unless the duty stabilizer is on
  always_comb begin
    clk_phase = phase;
    if (clock_reg[CLK_STAB_BIT]) // RULE9
      clk_phase = phase - PW'(32'(clock_reg[CLK_SHIFT_LSB +: 2]) * STEP); // RULE8
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.data_pair <= '0;
      link.over_range_flag <= 1'b0;
      link.forwarded_clock <= 1'b0;
      link.link_oe <= 1'b0;
    end else begin
      link.link_oe <= !outcfg_reg[OUT_DIS_BIT]; // RULE19
      if (!core_awake) begin
        link.forwarded_clock <= clock_reg[CLK_INV_BIT];
        link.data_pair <= '0;
        link.over_range_flag <= 1'b0;
      end else begin
        link.forwarded_clock <= (clk_phase >= PW'(HALF)) ^ clock_reg[CLK_INV_BIT]; // RULE10
        for (int i = 0; i < PAIRS; i++) begin
          link.data_pair[i] <= (phase < PW'(HALF)) ? out_word[2*i] : out_word[2*i+1]; // RULE1 RULE2
        end
        link.over_range_flag <= (phase < PW'(HALF)) && out_flag; // RULE6 RULE7
      end
    end
  end
endmodule
`default_nettype wire

// [adc_capture_end.sv]
// Receiver end: captures the DDR link, decodes the word, gates it after wake-up
`timescale 1ns/100ps
`default_nettype none
module adc_capture_end #(
  parameter int SLEEP_WAIT = adc_fmt_pkg::SLEEP_WAIT_CYC,
  parameter int NAP_WAIT = adc_fmt_pkg::NAP_WAIT_CYC,
  parameter int DIV = adc_fmt_pkg::LINK_DIV
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic wake_from_sleep, // Pulse: converter left sleep
  input wire logic wake_from_nap, // Pulse: converter left nap
  input wire logic clock_was_stopped, // Sampling clock halted during nap
  output logic [11:0] word_out, // Decoded word
  output logic over_out, // Over-range flag of the word
  output logic word_valid, // Pulse: usable word
  output logic data_usable, // Recovery wait over
  adc_link_if.receiver link // Input link
);
  import adc_fmt_pkg::*;

  localparam int STEP = DIV / PHASE_STEPS;
  localparam int DEPTH = 3 * STEP + 1;
  localparam int CW = $clog2(SLEEP_WAIT + 1);

  initial begin
    if (DIV < PHASE_STEPS || DIV % PHASE_STEPS != 0 || NAP_WAIT > SLEEP_WAIT)
      $error("Bad receiver parameters");
  end

  logic [7:0] ctrl_reg;
  logic [7:0] s1;
  logic [7:0] s2;
  logic s3_clk;
  logic [6:0] pipe [DEPTH];
  logic [6:0] late;
  logic [5:0] even_bits;
  logic even_flag;
  logic [CW-1:0] wait_count;
  logic [11:0] next_word;

  wire access = psel && penable;
  wire hit = (paddr == RX_CTRL_OFS) || (paddr == RX_WORD_OFS) || (paddr == RX_STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !hit;
      if (access && !pready && !pwrite) begin
        case (paddr)
          RX_CTRL_OFS: prdata <= {24'h000000, ctrl_reg};
          RX_WORD_OFS: prdata <= {19'h00000, over_out, word_out};
          RX_STATUS_OFS: prdata <= {31'h00000000, data_usable};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= REG_RESET;
    end else if (access && pready && pwrite && paddr == RX_CTRL_OFS) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // Two-stage synchronisers, then a tap line to undo the clock shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3_clk <= 1'b0;
      for (int i = 0; i < DEPTH; i++) pipe[i] <= 7'h00;
    end else begin
      s1 <= {link.forwarded_clock ^ ctrl_reg[RX_INV_BIT], link.over_range_flag, link.data_pair};
      s2 <= s1;
      s3_clk <= s2[7];
      pipe[0] <= s2[6:0];
      for (int i = 1; i < DEPTH; i++) pipe[i] <= pipe[i-1];
    end
  end

  always_comb begin
    late = pipe[32'(ctrl_reg[RX_SHIFT_LSB +: 2]) * STEP];
  end

  wire clk_rise = s2[7] && !s3_clk;
  wire clk_fall = !s2[7] && s3_clk;

  // Undo odd-bit inversion first, then the randomizer, mirroring the sender
  always_comb begin
    for (int i = 0; i < PAIRS; i++) begin
      next_word[2*i] = even_bits[i]; // RULE2
      next_word[2*i+1] = late[i];
    end
    if (ctrl_reg[RX_ALT_BIT]) next_word = next_word ^ 12'hAAA; // RULE16
    if (ctrl_reg[RX_RAND_BIT]) next_word[11:1] = next_word[11:1] ^ {11{next_word[0]}}; // RULE14
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_bits <= 6'h00;
      even_flag <= 1'b0;
      word_out <= 12'h000;
      over_out <= 1'b0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (clk_rise) begin
        even_bits <= late[5:0];
        even_flag <= late[6]; // RULE6
      end
      if (clk_fall && link.link_oe) begin
        word_out <= next_word;
        over_out <= even_flag;
        word_valid <= data_usable; // RULE21
      end
    end
  end

  // Recovery hold-off after sleep, or nap with a halted clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_count <= CW'(SLEEP_WAIT);
      data_usable <= 1'b0;
    end else if (wake_from_sleep || (wake_from_nap && clock_was_stopped)) begin
      wait_count <= CW'(SLEEP_WAIT); // RULE21 RULE23
      data_usable <= 1'b0;
    end else if (wake_from_nap) begin
      wait_count <= CW'(NAP_WAIT); // RULE22
      data_usable <= 1'b0;
    end else if (wait_count != '0) begin
      wait_count <= wait_count - CW'(1);
    end else begin
      data_usable <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [adc_link_checker.sv]
// Assertions on the DDR link between the converter end and the receiver end
`timescale 1ns/100ps
`default_nettype none
module adc_link_checker (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [adc_fmt_pkg::PAIRS-1:0] data_pair, // DDR data pairs
  input wire logic over_range_flag, // Flag line
  input wire logic forwarded_clock, // Clock true side
  input wire logic link_oe // Link driven
);
  default clocking cb @(posedge pclk);
  endclocking
  // Released outputs carry nothing worth judging
  default disable iff (!presetn || !link_oe);

  a_flag_second_half: assert property (forwarded_clock |-> !over_range_flag)
    else $error("flag high while clock high");
  a_flag_rise_low: assert property ($rose(over_range_flag) |-> !forwarded_clock)
    else $error("flag rose outside clock-low half");
  a_flag_one_half: assert property ($rose(over_range_flag) |->
    over_range_flag[*4] ##1 !over_range_flag)
    else $error("flag not held for exactly one half");
  a_flag_drop_edge: assert property ($fell(over_range_flag) |-> forwarded_clock)
    else $error("flag fell away from clock rise");
  a_clk_high_len: assert property ($rose(forwarded_clock) |->
    forwarded_clock[*4] ##1 !forwarded_clock)
    else $error("clock high half not four cycles");
  a_clk_low_len: assert property ($rose(forwarded_clock) |->
    !$past(forwarded_clock, 2) && !$past(forwarded_clock, 3) && !$past(forwarded_clock, 4))
    else $error("clock low half too short");
  a_odd_half_steady: assert property ($rose(forwarded_clock) |=> $stable(data_pair)[*3])
    else $error("odd bits moved within high half");
  a_even_half_steady: assert property ($fell(forwarded_clock) |=> $stable(data_pair)[*3])
    else $error("even bits moved within low half");
endmodule
`default_nettype wire

// [adc_output_formatter_bench.sv]
// Bench joining the converter output end to the receiver end
`timescale 1ns/100ps
`default_nettype none
module adc_output_formatter_bench;
  import adc_fmt_pkg::*;
  localparam int SLP = 40;
  localparam int NAP = 16;
  logic pclk, presetn, penable, pwrite, sel_dev, sel_rx;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd_dev, rd_rx;
  logic rdy_dev, rdy_rx, err_dev, err_rx;
  logic signed [12:0] sample_level;
  logic sample_valid, wake_from_sleep, wake_from_nap, clock_was_stopped;
  logic parallel_mode, power_down_pin;
  logic [13:0] drive_current_ua;
  logic termination_on, core_awake, data_settled, over_out, word_valid, data_usable;
  logic [11:0] word_out;
  logic [12:0] a, b;
  int n_errors = 0;
  int compares = 0;
  int lv[6] = '{0, 2047, 2048, -2048, -2049, 1365};
  logic [13:0] cur[8] = '{CUR_3500, CUR_4000, CUR_4500, CUR_3500, CUR_3000, CUR_2500,
    CUR_2100, CUR_1750};
  adc_link_if link ();
  adc_output_formatter i_adc_output_formatter (.pclk(pclk), .presetn(presetn), .psel(sel_dev),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(rd_dev),
    .pready(rdy_dev), .pslverr(err_dev), .sample_level(sample_level),
    .sample_valid(sample_valid), .parallel_mode(parallel_mode), .power_down_pin(power_down_pin),
    .drive_current_ua(drive_current_ua), .termination_on(termination_on),
    .core_awake(core_awake), .data_settled(data_settled), .link(link));
  adc_capture_end #(.SLEEP_WAIT(SLP), .NAP_WAIT(NAP)) i_adc_capture_end (.pclk(pclk),
    .presetn(presetn), .psel(sel_rx), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(rd_rx), .pready(rdy_rx), .pslverr(err_rx),
    .wake_from_sleep(wake_from_sleep), .wake_from_nap(wake_from_nap),
    .clock_was_stopped(clock_was_stopped), .word_out(word_out), .over_out(over_out),
    .word_valid(word_valid), .data_usable(data_usable), .link(link));
  adc_link_checker i_adc_link_checker (.pclk(pclk), .presetn(presetn),
    .data_pair(link.data_pair), .over_range_flag(link.over_range_flag),
    .forwarded_clock(link.forwarded_clock), .link_oe(link.link_oe));

  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Waits after every edge; the design's own updates of that edge are not yet seen
  task automatic apb(input bit rx, input bit wr, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    sel_dev <= !rx;
    sel_rx <= rx;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while ((rx ? rdy_rx : rdy_dev) !== 1'b1 && n < 20);
    q = rx ? rd_rx : rd_dev;
    e = rx ? err_rx : err_dev;
    sel_dev <= 1'b0;
    sel_rx <= 1'b0;
    penable <= 1'b0;
    if ((rx ? rdy_rx : rdy_dev) !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input bit rx, input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(rx, 1'b1, ad, d, q, e);
  endtask
  task automatic rd(input bit rx, input logic [7:0] ad, input logic [31:0] exp, input logic xe);
    logic [31:0] q;
    logic e;
    apb(rx, 1'b0, ad, 32'h0, q, e);
    chk("read data", exp, q);
    chk("slave error", 32'(xe), 32'(e));
  endtask
  function automatic logic probe(input int s);
    case (s)
      0: probe = word_valid;
      1: probe = !link.forwarded_clock;
      2: probe = link.forwarded_clock;
      default: probe = data_usable;
    endcase
  endfunction
  task automatic await(input int s, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (probe(s) !== 1'b1 && n < lim);
    if (probe(s) !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // Rebuilds {flag, D11..D0} from one link period, low half first
  task automatic grab(output logic [12:0] w);
    await(2, 40);
    await(1, 40);
    tick(2);
    for (int i = 0; i < 6; i++) w[2*i] = link.data_pair[i];
    w[12] = link.over_range_flag;
    await(2, 40);
    tick(2);
    for (int i = 0; i < 6; i++) w[2*i+1] = link.data_pair[i];
  endtask
  function automatic logic [12:0] enc(input int lvl, input logic [3:0] fmt);
    logic [11:0] c;
    logic f;
    f = lvl > 2047 || lvl < -2048;
    c = lvl > 2047 ? 12'hFFF : lvl < -2048 ? 12'h000 : 12'(lvl + 2048);
    if (fmt[0]) c[11] = !c[11];
    if (fmt[1]) c[11:1] = c[11:1] ^ {11{c[0]}};
    if (fmt[2]) c = c ^ 12'hAAA;
    return {f, c};
  endfunction
  task automatic send(input int lvl, input logic [3:0] fmt);
    logic [12:0] w;
    sample_level <= 13'(lvl);
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (3) await(0, 40);
    chk("received word", 32'(enc(lvl, {3'b000, fmt[0]})), 32'({over_out, word_out}));
    grab(w);
    chk("wire word", 32'(enc(lvl, fmt)), 32'(w));
  endtask
  task automatic wake_case(input bit slp, input bit stop, input int lim);
    int n;
    n = 2;
    wake_from_sleep <= slp;
    wake_from_nap <= !slp;
    clock_was_stopped <= stop;
    @(posedge pclk);
    wake_from_sleep <= 1'b0;
    wake_from_nap <= 1'b0;
    tick(2);
    while (data_usable !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("recovery wait ok", 32'h1, 32'(n >= lim && n <= lim + 4));
    clock_was_stopped <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    sel_dev = 1'b0;
    sel_rx = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_level = 13'h0000;
    sample_valid = 1'b0;
    wake_from_sleep = 1'b0;
    wake_from_nap = 1'b0;
    clock_was_stopped = 1'b0;
    parallel_mode = 1'b0;
    power_down_pin = 1'b0;
    tick(6);
    presetn <= 1'b1;
    for (int r = 0; r < 4; r++) rd(1'b0, 8'(4 * r), 32'h0, 1'b0);
    rd(1'b1, RX_CTRL_OFS, 32'h0, 1'b0);
    rd(1'b0, 8'h40, 32'h0, 1'b1);
    chk("drive current", 32'(CUR_3500), 32'(drive_current_ua));
    wake_case(1'b1, 1'b0, SLP);
    wake_case(1'b0, 1'b0, NAP);
    wake_case(1'b0, 1'b1, SLP);
    for (int f = 0; f < 8; f++) begin
      wr(1'b0, FORMAT_OFS, 32'(f));
      wr(1'b1, RX_CTRL_OFS, 32'(f >> 1));
      for (int k = 0; k < 6; k++) send(lv[k], 4'(f));
    end
    // Shift asked for with the stabilizer off must leave the link untouched
    wr(1'b0, CLOCK_OFS, 32'h6);
    send(2048, 4'h7);
    // Every other formatting bit on, so the pattern must override them
    for (int p = 0; p < 4; p++) begin
      wr(1'b0, FORMAT_OFS, 32'(16 * p + 15));
      grab(a);
      grab(a);
      grab(b);
      if (p < 2) chk("pattern", p ? 32'h0 : 32'h1FFF, 32'(b));
      else chk("pattern step", 32'(a ^ 13'h1FFF), 32'(b));
      if (p == 3) chk("checker", 32'h1, 32'(a === CHECKER_A || a === CHECKER_B));
    end
    for (int i = 0; i < 16; i++) begin
      wr(1'b0, OUTCFG_OFS, 32'(i));
      tick(2);
      chk("drive current", 32'(cur[i % 8]) << (i / 8), 32'(drive_current_ua));
      chk("termination", 32'(i / 8), 32'(termination_on));
    end
    wr(1'b0, OUTCFG_OFS, 32'h10);
    tick(2);
    chk("link enable", 32'h0, 32'(link.link_oe));
    // Pin sleep in parallel mode: two sync stages, then sleep and awake flops
    parallel_mode <= 1'b1;
    power_down_pin <= 1'b1;
    tick(5);
    chk("core awake", 32'h0, 32'(core_awake));
    parallel_mode <= 1'b0;
    power_down_pin <= 1'b0;
    wr(1'b0, POWER_OFS, 32'h1);
    tick(3);
    chk("core awake", 32'h0, 32'(core_awake));
    // Idle clock sits at the invert setting while the core is down
    wr(1'b0, CLOCK_OFS, 32'h8);
    tick(2);
    chk("clock idle level", 32'h1, 32'(link.forwarded_clock));
    wr(1'b0, CLOCK_OFS, 32'h0);
    wr(1'b0, POWER_OFS, 32'h2);
    tick(3);
    chk("core awake", 32'h0, 32'(core_awake));
    wr(1'b0, POWER_OFS, 32'h0);
    for (int n = 0; n < 1000 && data_settled !== 1'b1; n++) begin
      @(posedge pclk);
      a = 13'(n);
    end
    chk("nap settle ok", 32'h1, 32'(a >= 13'(NAP_WAIT_CYC - 3) && data_settled === 1'b1));
    wr(1'b0, OUTCFG_OFS, 32'h0);
    tick(2);
    chk("link enable", 32'h1, 32'(link.link_oe));
    give_verdict();
  end
endmodule
`default_nettype wire
